// ### rtl/xpsd_decoder.sv
`timescale 1ns/100ps

`include "xpsd_params.svh"

module xpsd_decoder
  import xpsd_pkg::*;
#(
  parameter int unsigned ADDR_W = 24
) (
  // clock, reset, enable
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_ce,
  // cpu access request
  input  wire xpsd_req_t        i_req,
  // global enable bit of the system configuration register
  input  wire logic             i_global_periph_bus_enable,
  // routed access and its cycle shape
  output logic                  o_route_valid,
  output xpsd_route_t           o_route,
  output logic [ADDR_W-1:0]     o_route_addr,
  output logic                  o_sel_hit,
  output logic [15:0]           o_sel_rdata,
  // visible peripherals and pin ownership
  output xpsd_en_t              o_active,
  output logic [3:0]            o_port4_gpio_free,
  output logic [3:0]            o_seg_lines
);

  // address window test, used for every range
  function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo,
                                    input logic [23:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // raw selection bits as fields
  function automatic xpsd_en_t sel_fields(input logic [15:0] s);
    xpsd_en_t e;
    e.net1 = s[`XPSD_BIT_NET1];
    e.net2 = s[`XPSD_BIT_NET2];
    e.extension_ram = s[`XPSD_BIT_EXTENSION_RAM];
    e.misc = s[`XPSD_BIT_MISC];
    e.pwm  = s[`XPSD_BIT_PWM];
    sel_fields = e;
  endfunction : sel_fields

  // global enable is a level from the same clock domain; no synchroniser needed
  logic [15:0] peripheral_selection_reg_q, peripheral_selection_reg_d;
  logic        lock_q, lock_d;
  xpsd_en_t    act;
  logic        sel_wr;

  assign sel_wr = i_req.valid && i_req.write && (i_req.addr == `XPSD_SEL_ADDR);

  // selection register next value; frozen once the global enable is seen
  always_comb begin
    peripheral_selection_reg_d = peripheral_selection_reg_q;
    lock_d                     = lock_q | i_global_periph_bus_enable;
    if (sel_wr && !lock_q && !i_global_periph_bus_enable) begin
      if (i_req.byte_acc) begin
        // only the low byte lane carries any implemented bits
        if (!i_req.addr[0]) begin
          peripheral_selection_reg_d = {8'h00, i_req.wdata[7:0]} & `XPSD_SEL_MASK;
        end
      end else begin
        peripheral_selection_reg_d = i_req.wdata & `XPSD_SEL_MASK;
      end
    end
  end

  // lock stays set until device reset; software cannot undo it
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      peripheral_selection_reg_q <= `XPSD_SEL_RESET;
      lock_q                     <= 1'b0;
    end else if (i_ce) begin
      peripheral_selection_reg_q <= peripheral_selection_reg_d;
      lock_q                     <= lock_d;
    end
  end

  // a peripheral exists only if chosen and the global enable has set the lock
  always_comb begin
    act = sel_fields(peripheral_selection_reg_q) & {5{lock_q}};
  end

  // route decode, next values
  xpsd_route_t       route_d, route_q;
  logic [ADDR_W-1:0] addr_d, addr_q;
  logic              hit_d, hit_q;
  logic [15:0]       rdata_d, rdata_q;

  always_comb begin
    route_d               = '0;
    route_d.valid         = i_req.valid;
    route_d.target        = XPSD_TGT_EXT;
    route_d.demux16       = 1'b0;
    route_d.waits         = 2'(`XPSD_FAST_WAITS);
    route_d.rw_delay      = 1'b0;
    route_d.tristate_wait = 1'b0;
    route_d.bit_addr_ok   = 1'b0;
    route_d.stack_ok      = 1'b0;
    addr_d                = i_req.addr[ADDR_W-1:0];
    hit_d                 = i_req.valid && (i_req.addr == `XPSD_SEL_ADDR);
    rdata_d               = peripheral_selection_reg_q & `XPSD_SEL_MASK;
    if (in_range(i_req.addr, `XPSD_INTERNAL_DUAL_PORT_RAM_LO, `XPSD_INTERNAL_DUAL_PORT_RAM_HI)) begin
      // holds stack and the sixteen-word register bank
      route_d.target      = XPSD_TGT_INTERNAL_DUAL_PORT_RAM;
      route_d.bit_addr_ok = 1'b1;
      route_d.stack_ok    = 1'b1;
    end else if (in_range(i_req.addr, `XPSD_SFR_LO, `XPSD_SFR_HI) ||
                 in_range(i_req.addr, `XPSD_EXTENDED_FUNCTION_REG_AREA_LO, `XPSD_EXTENDED_FUNCTION_REG_AREA_HI)) begin
      route_d.target = XPSD_TGT_SFR;
    end else if (in_range(i_req.addr, `XPSD_EXTENSION_RAM_LO, `XPSD_EXTENSION_RAM_HI) && act.extension_ram) begin
      route_d.target  = XPSD_TGT_EXTENSION_RAM;
      route_d.demux16 = 1'b1;
      route_d.waits   = 2'(`XPSD_FAST_WAITS);
      route_d.bit_addr_ok = 1'b0;
      route_d.stack_ok    = 1'b0;
    end else if (in_range(i_req.addr, `XPSD_NET1_LO, `XPSD_NET1_HI) && act.net1) begin
      route_d.target  = XPSD_TGT_NET1;
      route_d.demux16 = 1'b1;
      route_d.waits   = 2'(`XPSD_SLOW_WAITS);
    end else if (in_range(i_req.addr, `XPSD_NET2_LO, `XPSD_NET2_HI) && act.net2) begin
      route_d.target  = XPSD_TGT_NET2;
      route_d.demux16 = 1'b1;
      route_d.waits   = 2'(`XPSD_SLOW_WAITS);
    end else if (in_range(i_req.addr, `XPSD_PWM_LO, `XPSD_PWM_HI) && act.pwm) begin
      route_d.target  = XPSD_TGT_PWM;
      route_d.demux16 = 1'b1;
      route_d.waits   = 2'(`XPSD_SLOW_WAITS);
    end else if (in_range(i_req.addr, `XPSD_MISC_LO, `XPSD_MISC_HI) && act.misc) begin
      route_d.target  = XPSD_TGT_MISC;
      route_d.demux16 = 1'b1;
      route_d.waits   = 2'(`XPSD_FAST_WAITS);
    end else if (in_range(i_req.addr, `XPSD_PWM_LO, `XPSD_NET1_HI) &&
                 (act.net1 || act.net2 || act.pwm)) begin
      // gaps in the peripheral window stay claimed while any of them lives
      route_d.target = XPSD_TGT_SFR;
    end else begin
      // disabled ranges not claimed by the gap branch above fall through to the external interface
      route_d.target = XPSD_TGT_EXT;
    end
  end

  // registered answer: one cycle after the request
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      route_q <= '0;
      addr_q  <= '0;
      hit_q   <= 1'b0;
      rdata_q <= 16'h0000;
    end else if (i_ce) begin
      route_q <= route_d;
      addr_q  <= addr_d;
      hit_q   <= hit_d;
      rdata_q <= rdata_d;
    end
  end

  // pin ownership: p4.4..p4.7 as bits 0..3
  logic [3:0] gpio_d, gpio_q;
  logic [3:0] seg_d, seg_q;

  always_comb begin
    gpio_d    = 4'hF;
    gpio_d[1] = !act.net1;
    gpio_d[2] = !act.net1;
    gpio_d[0] = !act.net2;
    gpio_d[3] = !act.net2;
    seg_d     = (act.net1 || act.net2) ? 4'(`XPSD_SEG_LINES_NET) : 4'(`XPSD_SEG_LINES_FULL);
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      gpio_q <= 4'hF;
      seg_q  <= 4'(`XPSD_SEG_LINES_FULL);
    end else if (i_ce) begin
      gpio_q <= gpio_d;
      seg_q  <= seg_d;
    end
  end

  // outputs
  assign o_route_valid     = route_q.valid;
  assign o_route           = route_q;
  assign o_route_addr      = addr_q;
  assign o_sel_hit         = hit_q;
  assign o_sel_rdata       = rdata_q;
  assign o_active          = act;
  assign o_port4_gpio_free = gpio_q;
  assign o_seg_lines       = seg_q;

endmodule : xpsd_decoder

// ### rtl/xpsd_params.svh
`ifndef XPSD_PARAMS_SVH
`define XPSD_PARAMS_SVH

// selection register location in the extended function register area
`define XPSD_SEL_ADDR        24'h00_F024
`define XPSD_SEL_SHORT       8'h12
`define XPSD_SEL_RESET       16'h0005
`define XPSD_SEL_MASK        16'h001F

// selection register field positions
`define XPSD_BIT_NET1        0
`define XPSD_BIT_NET2        1
`define XPSD_BIT_EXTENSION_RAM        2
`define XPSD_BIT_MISC        3
`define XPSD_BIT_PWM         4

// address windows, inclusive bounds
`define XPSD_INTERNAL_DUAL_PORT_RAM_LO         24'h00_F600
`define XPSD_INTERNAL_DUAL_PORT_RAM_HI         24'h00_FDFF
`define XPSD_EXTENSION_RAM_LO         24'h00_8000
`define XPSD_EXTENSION_RAM_HI         24'h00_BFFF
`define XPSD_NET1_LO         24'h00_EF00
`define XPSD_NET1_HI         24'h00_EFFF
`define XPSD_NET2_LO         24'h00_EE00
`define XPSD_NET2_HI         24'h00_EEFF
`define XPSD_PWM_LO          24'h00_EC00
`define XPSD_PWM_HI          24'h00_ECFF
`define XPSD_MISC_LO         24'h00_C000
`define XPSD_MISC_HI         24'h00_C3FF
`define XPSD_SFR_LO          24'h00_FE00
`define XPSD_SFR_HI          24'h00_FFFF
`define XPSD_EXTENDED_FUNCTION_REG_AREA_LO         24'h00_F000
`define XPSD_EXTENDED_FUNCTION_REG_AREA_HI         24'h00_F1FF

// register bank: 16 words, low eight split in byte halves
`define XPSD_GPR_WORDS       16
`define XPSD_GPR_BYTE_REGS   8

// slow peripheral access time and the cpu clock it is quoted at
`define XPSD_SLOW_ACCESS_NS  100
`define XPSD_CPU_MHZ         40
`define XPSD_CPU_PERIOD_NS   25
`define XPSD_SLOW_WAITS      ((`XPSD_SLOW_ACCESS_NS / `XPSD_CPU_PERIOD_NS) - 2)
`define XPSD_FAST_WAITS      0

// segment address lines on the fourth port
`define XPSD_SEG_LINES_FULL  8
`define XPSD_SEG_LINES_NET   4

`endif

// ### rtl/xpsd_pkg.sv
package xpsd_pkg;

  // where a cpu access ends up
  typedef enum logic [2:0] {
    XPSD_TGT_EXT,
    XPSD_TGT_INTERNAL_DUAL_PORT_RAM,
    XPSD_TGT_EXTENSION_RAM,
    XPSD_TGT_NET1,
    XPSD_TGT_NET2,
    XPSD_TGT_PWM,
    XPSD_TGT_MISC,
    XPSD_TGT_SFR
  } xpsd_tgt_t;

  // cpu request carried into the decoder
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        byte_acc;
    logic [23:0] addr;
    logic [15:0] wdata;
  } xpsd_req_t;

  // routed access with its bus cycle shape
  typedef struct packed {
    logic        valid;
    xpsd_tgt_t   target;
    logic        demux16;
    logic [1:0]  waits;
    logic        rw_delay;
    logic        tristate_wait;
    logic        bit_addr_ok;
    logic        stack_ok;
  } xpsd_route_t;

  // enables as seen by the rest of the chip
  typedef struct packed {
    logic pwm;
    logic misc;
    logic extension_ram;
    logic net2;
    logic net1;
  } xpsd_en_t;

endpackage : xpsd_pkg

// ### verification/xpsd_chk_props.sv
`timescale 1ns/100ps
`include "xpsd_params.svh"
module xpsd_chk
  import xpsd_pkg::*;
#(parameter int unsigned ADDR_W = 24) (
  // clock and reset
  input wire logic              i_clk,
  input wire logic              i_rstn,
  // watched ports
  input wire logic              i_ce,
  input wire xpsd_req_t         i_req,
  input wire logic              o_route_valid,
  input wire xpsd_route_t       o_route,
  input wire logic [ADDR_W-1:0] o_route_addr,
  input wire xpsd_en_t          o_active,
  input wire logic [3:0]        o_port4_gpio_free,
  input wire logic [3:0]        o_seg_lines
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // request taken at this edge inside a window
  sequence s_take(lo, hi);
    i_ce && i_req.valid && i_req.addr >= lo && i_req.addr <= hi;
  endsequence
  // no module owns the shared hole
  sequence s_none;
    !(o_active.net1 || o_active.net2 || o_active.pwm);
  endsequence
  property p_answer;
    i_ce && i_req.valid |=> o_route_valid && o_route_addr == $past(i_req.addr);
  endproperty
  property p_internal_dual_port_ram;
    s_take(`XPSD_INTERNAL_DUAL_PORT_RAM_LO, `XPSD_INTERNAL_DUAL_PORT_RAM_HI) |=> o_route.target == XPSD_TGT_INTERNAL_DUAL_PORT_RAM;
  endproperty
  property p_hole;
    s_take(`XPSD_PWM_LO, `XPSD_NET1_HI) ##0 s_none |=> o_route.target == XPSD_TGT_EXT;
  endproperty
  property p_slow;
    o_route_valid && o_route.target inside {XPSD_TGT_NET1, XPSD_TGT_NET2, XPSD_TGT_PWM}
      |-> o_route.waits == 2'd2 && o_route.demux16 && !o_route.tristate_wait;
  endproperty
  property p_extension_ram;
    o_route_valid && o_route.target == XPSD_TGT_EXTENSION_RAM |-> o_route.waits == 2'd0 && o_route.demux16
      && !o_route.rw_delay && !o_route.bit_addr_ok && !o_route.stack_ok;
  endproperty
  // seg lines lag the enables by one register stage
  property p_seg;
    (o_active.net1 || o_active.net2) [*2] |-> o_seg_lines == 4'h4;
  endproperty
  property p_gpio;
    !o_active.net1 [*2] |-> o_port4_gpio_free[2:1] == 2'b11;
  endproperty
  // once locked the visible set can never move
  property p_lock;
    o_active != 5'h00 |=> $stable(o_active);
  endproperty
  a_answer: assert property (p_answer) else $error("route not answered");
  a_internal_dual_port_ram: assert property (p_internal_dual_port_ram) else $error("internal_dual_port_ram miss");
  a_hole: assert property (p_hole) else $error("hole not external");
  a_slow: assert property (p_slow) else $error("slow shape wrong");
  a_extension_ram: assert property (p_extension_ram) else $error("extension_ram shape wrong");
  a_seg: assert property (p_seg) else $error("seg lines not reduced");
  a_gpio: assert property (p_gpio) else $error("pins not freed");
  a_lock: assert property (p_lock) else $error("enables moved");
endmodule : xpsd_chk

// ### verification/xpsd_cpu_model.sv
`timescale 1ns/100ps
module xpsd_cpu_model
  import xpsd_pkg::*;
(
  // cpu clock
  input  wire logic i_clk,
  // request and global enable towards the decoder
  output xpsd_req_t o_req,
  output logic      o_gen
);
  // idle bus at time zero
  initial begin
    o_req = '0;
    o_gen = 1'b0;
  end
  // one word or byte request held for exactly one taking edge
  task automatic access(input logic wr, input logic [23:0] a, input logic [15:0] d,
                        input logic b = 1'b0);
    @(posedge i_clk);
    o_req <= {1'b1, wr, b, a, d};
    @(posedge i_clk);
    o_req.valid <= 1'b0;
    o_req.addr <= ~a; // released address must not look valid
    #1;
  endtask : access
  // software picks the set first, then enables the bus
  task automatic set_gen(input logic v);
    @(posedge i_clk);
    o_gen <= v;
    @(posedge i_clk);
    #1;
  endtask : set_gen
endmodule : xpsd_cpu_model

// ### verification/tb.sv
`timescale 1ns/100ps
module tb;
  import xpsd_pkg::*;
  logic        i_clk, i_rstn, i_ce, gen, route_valid, sel_hit, lock;
  xpsd_req_t   req;
  xpsd_route_t route;
  xpsd_en_t    active;
  logic [23:0] route_addr;
  logic [15:0] sel_rdata, rnd, sel;
  logic [3:0]  gpio, seg;
  logic [4:0]  e;
  logic [7:0]  hib [16] = '{8'h80, 8'hBF, 8'hC0, 8'hC3, 8'hEC, 8'hED, 8'hEE, 8'hEF,
                            8'hF0, 8'hF6, 8'hFD, 8'hFE, 8'h10, 8'hE0, 8'hC4, 8'hFF};
  logic [15:0] cfg [4] = '{16'hFFFF, 16'h0000, 16'h001A, 16'h0005};
  int          fail_count = 0, cmp_count = 0, cyc = 0;
  xpsd_decoder u_xpsd_decoder (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_req(req),
    .i_global_periph_bus_enable(gen), .o_route_valid(route_valid), .o_route(route),
    .o_route_addr(route_addr), .o_sel_hit(sel_hit), .o_sel_rdata(sel_rdata), .o_active(active),
    .o_port4_gpio_free(gpio), .o_seg_lines(seg));
  xpsd_cpu_model u_xpsd_cpu_model (.i_clk(i_clk), .o_req(req), .o_gen(gen));
  // clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // hang guard, the full run needs under a thousand cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      end_of_test();
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // reference map for one address and the visible set
  function automatic xpsd_tgt_t exp_tgt(input logic [23:0] x, input logic [4:0] m);
    logic [15:0] y;
    y = x[15:0];
    if (x[23:16] != 8'h00) return XPSD_TGT_EXT;
    if (y >= 16'hF600 && y <= 16'hFDFF) return XPSD_TGT_INTERNAL_DUAL_PORT_RAM;
    if (y >= 16'hFE00 || y[15:9] == 7'h78) return XPSD_TGT_SFR;
    if (y[15:14] == 2'b10) return m[2] ? XPSD_TGT_EXTENSION_RAM : XPSD_TGT_EXT;
    if (y[15:8] == 8'hEF && m[0]) return XPSD_TGT_NET1;
    if (y[15:8] == 8'hEE && m[1]) return XPSD_TGT_NET2;
    if (y[15:8] == 8'hEC && m[4]) return XPSD_TGT_PWM;
    if (y[15:10] == 6'h3B) return (m[0] | m[1] | m[4]) ? XPSD_TGT_SFR : XPSD_TGT_EXT;
    if (y[15:10] == 6'h30 && m[3]) return XPSD_TGT_MISC;
    return XPSD_TGT_EXT;
  endfunction : exp_tgt
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // one access, then valid, address, target, select hit, read data, enables and pins against the model
  task automatic acc(input logic wr, input logic [23:0] x, input logic [15:0] d,
                     input logic b = 1'b0);
    e = sel[4:0] & {5{lock}};
    u_xpsd_cpu_model.access(wr, x, d, b);
    check(24'(route_valid), 24'h00_0001);
    check(route_addr, x);
    check(24'(route.target), 24'(exp_tgt(x, e)));
    check(24'(sel_hit), 24'(x == 24'h00_F024));
    if (!wr && x == 24'h00_F024) check(24'(sel_rdata), 24'(sel));
    if (wr && x == 24'h00_F024 && !lock) sel = d & 16'h001F;
    check(24'(active), 24'(e));
    check({16'h0000, gpio, seg}, {16'h0000, ~e[1], ~e[0], ~e[0], ~e[1], ((e[0] | e[1]) ? 4'h4 : 4'h8)});
  endtask : acc
  task automatic end_of_test();
    $display("comparisons=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  // per set: program, lock, try to change, then random traffic
  initial begin
    i_rstn = 1'b0;
    i_ce = 1'b1;
    rnd = 16'd18968;
    for (int k = 0; k < 4; k++) begin
      sel = 16'h0005;
      lock = 1'b0;
      repeat (10) @(posedge i_clk);
      i_rstn <= 1'b1;
      acc(1'b0, 24'h00_F024, 16'h0000);
      acc(1'b1, 24'h00_F024, 16'hFF12, 1'b1);
      acc(1'b0, 24'h00_F024, 16'h0000);
      acc(1'b1, 24'h00_F024, cfg[k]);
      acc(1'b0, 24'h00_F024, 16'h0000);
      u_xpsd_cpu_model.set_gen(1'b1);
      lock = 1'b1;
      acc(1'b1, 24'h00_F024, ~cfg[k]);
      acc(1'b0, 24'h00_F024, 16'h0000);
      for (int n = 0; n < 60; n++) begin
        rnd = lfsr(rnd);
        acc(rnd[14], {7'h00, rnd[12] & rnd[13], hib[rnd[3:0]], rnd[11:4]}, rnd);
      end
      u_xpsd_cpu_model.set_gen(1'b0);
      @(posedge i_clk);
      i_rstn <= 1'b0;
    end
    end_of_test();
  end
endmodule : tb

bind xpsd_decoder xpsd_chk #(.ADDR_W(ADDR_W)) u_xpsd_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce),
  .i_req(i_req), .o_route_valid(o_route_valid), .o_route(o_route), .o_route_addr(o_route_addr),
  .o_active(o_active), .o_port4_gpio_free(o_port4_gpio_free), .o_seg_lines(o_seg_lines));
